/* logic/jcc_top.sv */
// jtag configuration control: instruction decode, flash bridge, io reload, park
`timescale 1ns/1ps
module jcc_top
  import jcc_pkg::*;
#(
  parameter int unsigned    IR_W        = IR_W_DEF,
  parameter logic [IR_W-1:0] OP_RECONFIG = IR_W'(OP_RECONFIG_DEF),
  parameter logic [IR_W-1:0] OP_IO_LOAD  = IR_W'(OP_IO_LOAD_DEF),
  parameter logic [IR_W-1:0] OP_PARK     = IR_W'(OP_PARK_DEF),
  parameter logic [IR_W-1:0] OP_RESUME   = IR_W'(OP_RESUME_DEF),
  parameter logic [IR_W-1:0] OP_BRIDGE   = IR_W'(OP_BRIDGE_DEF),
  parameter int unsigned    PWRUP_WAIT  = IO_WAIT_CYC
)
(
  // clock and reset
  input  wire logic          CORE_CLK,
  input  wire logic          RESETN,
  // tap pins
  input  wire logic          TCK,
  input  wire logic          TMS,
  input  wire logic          TDI,
  output logic               TDO,
  // configuration pins and core status
  input  wire jcc_pkg::jcc_scheme_t SCHEME_SELECT_PINS,
  input  wire logic          CONFIG_REQUEST_PIN_N,
  input  wire logic          STATUS_LINE_N,
  input  wire logic          CONFIG_DONE_LINE,
  input  wire logic          BRIDGE_LOADED,
  input  wire logic          USER_MODE_REACHED,
  // serial memory pins
  output logic               SERIAL_FLASH_CLOCK,
  output logic               ACTIVE_SERIAL_DATA_IN,
  output logic               FLASH_CHIP_SELECT_N,
  output logic               SERIAL_MEMORY_OE,
  input  wire logic          ACTIVE_SERIAL_DATA_OUT,
  // configuration control outputs
  output logic               ENTER_USER_MODE,
  output logic               RECONFIG_REQ,
  output logic               IO_CHAIN_RELOAD,
  output logic               USER_IO_HIZ,
  output logic               ACTIVE_CTRL_PARKED
);

  typedef struct packed {
    logic                 tck_d;
    logic [IR_W-1:0]      ir_sr;
    logic [IR_W-1:0]      ir;
    logic                 byp;
    logic                 tdo;
    logic                 pwrup_done;
    logic [PWR_CNT_W-1:0] pwr_cnt;
    logic                 parked;
    logic                 io_active;
    logic                 bridge;
    logic                 reconfig;
    logic                 io_load;
    logic                 sfc;
    logic                 active_serial_data_in;
    logic                 cs_n;
    logic                 user_d;
    logic                 stat_d;
  } jcc_top_st_t;

  jcc_top_st_t cur_ff;
  jcc_top_st_t nxt_cur;
  logic        rst_meta_ff;
  logic        rst_sync_ff;
  logic        tck_rise;
  logic        upd_ir;
  logic        active_sch;
  logic        bridge_sel;
  logic        cmd_reconfig;
  logic        cmd_resume;

  jcc_tap_if u_tif ();

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // tck is taken as synchronous; its rising edge becomes a one-cycle enable
  assign tck_rise       = TCK & ~cur_ff.tck_d;
  assign u_tif.tck_rise = tck_rise;
  assign u_tif.tms      = TMS;

  jcc_tap u_tap (
    .clk   (CORE_CLK),
    .rst_n (rst_sync_ff),
    .tif   (u_tif.tap)
  );

  assign upd_ir       = tck_rise && (u_tif.st == TAP_UPD_IR);
  assign active_sch   = SCHEME_SELECT_PINS[1];
  assign bridge_sel   = cur_ff.bridge && (cur_ff.ir == OP_BRIDGE);
  assign cmd_reconfig = upd_ir && (cur_ff.ir_sr == OP_RECONFIG);
  assign cmd_resume   = upd_ir && (cur_ff.ir_sr == OP_RESUME);

  always_comb
  begin
    nxt_cur          = cur_ff;
    nxt_cur.tck_d    = TCK;
    nxt_cur.user_d   = USER_MODE_REACHED;
    nxt_cur.stat_d   = STATUS_LINE_N;
    nxt_cur.reconfig = 1'b0;
    nxt_cur.io_load  = 1'b0;

    // power-up window: io load is refused until the wait elapses or status rises
    if (!cur_ff.pwrup_done)
    begin
      if (STATUS_LINE_N && !cur_ff.stat_d)
        nxt_cur.pwrup_done = 1'b1;
      else if (!CONFIG_REQUEST_PIN_N)
        nxt_cur.pwr_cnt = '0;
      else if (cur_ff.pwr_cnt >= PWR_CNT_W'(PWRUP_WAIT - 1))
        nxt_cur.pwrup_done = 1'b1;
      else
        nxt_cur.pwr_cnt = cur_ff.pwr_cnt + PWR_CNT_W'(1);
    end

    if (tck_rise)
    begin
      case (u_tif.st)
        TAP_RESET:
        begin
          nxt_cur.ir = '1;
          nxt_cur.io_active = 1'b0;
          // a tap reset re-engages the serial controller, not the parallel one
          if (SCHEME_SELECT_PINS == SCH_ACTIVE_SERIAL)
            nxt_cur.parked = 1'b0;
        end
        TAP_CAP_IR:   nxt_cur.ir_sr = IR_W'(1);
        TAP_SHIFT_IR: nxt_cur.ir_sr = {TDI, cur_ff.ir_sr[IR_W-1:1]};
        TAP_CAP_DR:   nxt_cur.byp = 1'b0;
        TAP_SHIFT_DR: nxt_cur.byp = TDI;
        TAP_UPD_IR:
        begin
          nxt_cur.ir = cur_ff.ir_sr;
          if (cur_ff.ir_sr == OP_IO_LOAD && cur_ff.pwrup_done)
          begin
            nxt_cur.io_active = 1'b1;
            nxt_cur.io_load   = 1'b1;
          end
          if (cur_ff.ir_sr == OP_PARK && active_sch)
            nxt_cur.parked = 1'b1;
          if (cur_ff.ir_sr == OP_RESUME)
            nxt_cur.parked = 1'b0;
        end
        default:
        begin
          nxt_cur.byp = cur_ff.byp;
        end
      endcase
    end

    // flash data is set up while tck is low, ahead of the flash clock rise
    if (!TCK && u_tif.st == TAP_SHIFT_DR)
      nxt_cur.active_serial_data_in = TDI;

    // the flash is only touched by explicit jtag traffic, never by itself
    if (cmd_reconfig || cmd_resume)
      nxt_cur.reconfig = 1'b1;

    if (cur_ff.reconfig || !CONFIG_REQUEST_PIN_N)
      nxt_cur.bridge = 1'b0;
    else if (BRIDGE_LOADED)
      nxt_cur.bridge = 1'b1;

    if (USER_MODE_REACHED && !cur_ff.user_d)
      nxt_cur.parked = 1'b0;

    // bridge path: tck mirrored onto the flash clock only while shifting
    nxt_cur.cs_n = !(bridge_sel && (u_tif.st == TAP_SHIFT_DR));
    // no clock pulse on entry to shift-dr, only after a shifting rise
    nxt_cur.sfc  = bridge_sel && TCK && (u_tif.st == TAP_SHIFT_DR) &&
                   (tck_rise || cur_ff.sfc);
    if (u_tif.st == TAP_SHIFT_IR)
      nxt_cur.tdo = cur_ff.ir_sr[0];
    else if (bridge_sel)
      nxt_cur.tdo = ACTIVE_SERIAL_DATA_OUT;
    else
      nxt_cur.tdo = cur_ff.byp;
  end

  always_ff @(posedge CORE_CLK or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      cur_ff            <= '0;
      cur_ff.ir         <= '1;
      cur_ff.ir_sr      <= '1;
      cur_ff.cs_n       <= 1'b1;
      // a tck or status already high at release is not an edge
      cur_ff.tck_d      <= 1'b1;
      cur_ff.stat_d     <= 1'b1;
    end
    else
      cur_ff <= nxt_cur;
  end

  assign TDO                   = cur_ff.tdo;
  assign SERIAL_FLASH_CLOCK    = cur_ff.sfc;
  assign ACTIVE_SERIAL_DATA_IN = cur_ff.active_serial_data_in;
  assign FLASH_CHIP_SELECT_N   = cur_ff.cs_n;
  // pins released once the bridge is gone so the flash can configure the chain
  assign SERIAL_MEMORY_OE      = cur_ff.bridge;
  assign ENTER_USER_MODE       = CONFIG_DONE_LINE | cur_ff.bridge;
  assign RECONFIG_REQ          = cur_ff.reconfig;
  assign IO_CHAIN_RELOAD       = cur_ff.io_load;
  assign USER_IO_HIZ           = cur_ff.io_active;
  assign ACTIVE_CTRL_PARKED    = cur_ff.parked;

  property p_cs_needs_bridge;
    @(posedge CORE_CLK) disable iff (!rst_sync_ff)
      !FLASH_CHIP_SELECT_N |-> $past(cur_ff.bridge) && $past(cur_ff.ir == OP_BRIDGE);
  endproperty
  a_cs_needs_bridge: assert property (p_cs_needs_bridge)
    else $error("flash selected without bridge instruction");

  property p_user_with_bridge;
    @(posedge CORE_CLK) disable iff (!rst_sync_ff)
      (BRIDGE_LOADED && CONFIG_REQUEST_PIN_N && !RECONFIG_REQ) |=> ENTER_USER_MODE;
  endproperty
  a_user_with_bridge: assert property (p_user_with_bridge)
    else $error("bridge loaded but user mode not entered");

  property p_reconfig_cause;
    @(posedge CORE_CLK) disable iff (!rst_sync_ff)
      RECONFIG_REQ |-> $past(cmd_reconfig || cmd_resume);
  endproperty
  a_reconfig_cause: assert property (p_reconfig_cause)
    else $error("reconfiguration without instruction");

  property p_instr_reconfig;
    @(posedge CORE_CLK) disable iff (!rst_sync_ff)
      (cmd_reconfig || cmd_resume) |=> RECONFIG_REQ ##1 !SERIAL_MEMORY_OE;
  endproperty
  a_instr_reconfig: assert property (p_instr_reconfig)
    else $error("reconfiguration did not remove the bridge");

  property p_io_not_pwrup;
    @(posedge CORE_CLK) disable iff (!rst_sync_ff)
      IO_CHAIN_RELOAD |-> $past(cur_ff.pwrup_done) && USER_IO_HIZ;
  endproperty
  a_io_not_pwrup: assert property (p_io_not_pwrup)
    else $error("io reload during power-up");

  property p_io_ends_tap_reset;
    @(posedge CORE_CLK) disable iff (!rst_sync_ff)
      $fell(USER_IO_HIZ) |-> $past(u_tif.st) == TAP_RESET;
  endproperty
  a_io_ends_tap_reset: assert property (p_io_ends_tap_reset)
    else $error("io high impedance ended without tap reset");

  property p_io_no_reconfig;
    @(posedge CORE_CLK) disable iff (!rst_sync_ff)
      IO_CHAIN_RELOAD |-> !RECONFIG_REQ;
  endproperty
  a_io_no_reconfig: assert property (p_io_no_reconfig)
    else $error("io reload caused reconfiguration");

  property p_park_active_only;
    @(posedge CORE_CLK) disable iff (!rst_sync_ff)
      $rose(ACTIVE_CTRL_PARKED) |-> $past(active_sch) && $past(upd_ir);
  endproperty
  a_park_active_only: assert property (p_park_active_only)
    else $error("park took effect in passive scheme");

  property p_user_unparks;
    @(posedge CORE_CLK) disable iff (!rst_sync_ff)
      (USER_MODE_REACHED && !cur_ff.user_d) |=> !ACTIVE_CTRL_PARKED;
  endproperty
  a_user_unparks: assert property (p_user_unparks)
    else $error("parked controller not re-engaged at user mode");

  c_reconfig: cover property (@(posedge CORE_CLK) disable iff (!rst_sync_ff) RECONFIG_REQ);
  c_io_load:  cover property (@(posedge CORE_CLK) disable iff (!rst_sync_ff) IO_CHAIN_RELOAD);
  c_flash:    cover property (@(posedge CORE_CLK) disable iff (!rst_sync_ff)
                              !FLASH_CHIP_SELECT_N ##1 SERIAL_FLASH_CLOCK);
  c_park:     cover property (@(posedge CORE_CLK) disable iff (!rst_sync_ff)
                              $rose(ACTIVE_CTRL_PARKED));

endmodule : jcc_top

/* pkg/jcc_pkg.sv */
// constants, types and timing for the jtag configuration control block
// Notes on behaviour
// - loaded bridge connects jtag to the serial memory pins for full flash access
// - master with the bridge enters user mode despite config done held low
// - host sends flash data over jtag; device forwards it on the memory pins
// - no reconfiguration after flash write until the reconfig pulse instruction
// - reconfiguration resets the master and removes the bridge
// - io config load reloads the io shift chain, accepted anytime in user mode
// - io load refused in power-up; its flow ends with a tap reset
// - io config load never holds the status line low
// - park instruction idles the active configuration controller
// - reaching user mode re-engages a parked active controller
// - all user io are high impedance while io config load runs
// - resume also triggers reconfiguration
// - park has no effect in passive schemes
// - in passive schemes resume acts as the reconfig pulse instruction
package jcc_pkg;

  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned IO_WAIT_US  = 230;
  localparam int unsigned IO_WAIT_CYC = IO_WAIT_US * CLK_MHZ;
  localparam int unsigned PWR_CNT_W   = 16;
  localparam int unsigned IR_W_DEF    = 10;

  localparam logic [9:0] OP_RECONFIG_DEF = 10'h001;
  localparam logic [9:0] OP_IO_LOAD_DEF  = 10'h00D;
  localparam logic [9:0] OP_PARK_DEF     = 10'h2D0;
  localparam logic [9:0] OP_RESUME_DEF   = 10'h2B0;
  localparam logic [9:0] OP_BRIDGE_DEF   = 10'h00E;

  // scheme straps: bit 1 set means an active scheme
  typedef enum logic [1:0] {
    SCH_ACTIVE_SERIAL   = 2'h2,
    SCH_ACTIVE_PARALLEL = 2'h3,
    SCH_PASSIVE_SERIAL  = 2'h0,
    SCH_FAST_PASSIVE    = 2'h1
  } jcc_scheme_t;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jcc_tap_state_t;

endpackage : jcc_pkg

/* pkg/jcc_tap_if.sv */
// tap strobe and state bundle between the top and the tap sequencer
`timescale 1ns/1ps
interface jcc_tap_if;
  import jcc_pkg::*;
  logic           tck_rise;
  logic           tms;
  jcc_tap_state_t st;

  modport tap  (input tck_rise, input tms, output st);
  modport core (output tck_rise, output tms, input st);
endinterface : jcc_tap_if

/* logic/jcc_tap.sv */
// ieee 1149.1 tap state sequencer, stepped by the tck rising-edge enable
`timescale 1ns/1ps
module jcc_tap
  import jcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // tap strobes and state
  jcc_tap_if.tap   tif
);

  typedef struct packed {
    jcc_tap_state_t st;
  } jcc_tap_st_t;

  jcc_tap_st_t cur_ff;
  jcc_tap_st_t nxt_cur;

  assign tif.st = cur_ff.st;

  always_comb
  begin
    nxt_cur = cur_ff;
    if (tif.tck_rise)
    begin
      case (cur_ff.st)
        TAP_RESET:    nxt_cur.st = tif.tms ? TAP_RESET    : TAP_IDLE;
        TAP_IDLE:     nxt_cur.st = tif.tms ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_DR:   nxt_cur.st = tif.tms ? TAP_SEL_IR   : TAP_CAP_DR;
        TAP_CAP_DR:   nxt_cur.st = tif.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: nxt_cur.st = tif.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: nxt_cur.st = tif.tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
        TAP_PAUSE_DR: nxt_cur.st = tif.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: nxt_cur.st = tif.tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
        TAP_UPD_DR:   nxt_cur.st = tif.tms ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_IR:   nxt_cur.st = tif.tms ? TAP_RESET    : TAP_CAP_IR;
        TAP_CAP_IR:   nxt_cur.st = tif.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: nxt_cur.st = tif.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: nxt_cur.st = tif.tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
        TAP_PAUSE_IR: nxt_cur.st = tif.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: nxt_cur.st = tif.tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
        TAP_UPD_IR:   nxt_cur.st = tif.tms ? TAP_SEL_DR   : TAP_IDLE;
        default:      nxt_cur.st = TAP_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cur_ff <= '{st: TAP_RESET};
    else
      cur_ff <= nxt_cur;
  end

  property p_tap_reset_holds;
    @(posedge clk) disable iff (!rst_n)
      (cur_ff.st == TAP_RESET && tif.tck_rise && tif.tms) |=> (cur_ff.st == TAP_RESET);
  endproperty
  a_tap_reset_holds: assert property (p_tap_reset_holds)
    else $error("tap left reset with tms high");

  property p_tap_still;
    @(posedge clk) disable iff (!rst_n)
      !tif.tck_rise |=> $stable(cur_ff.st);
  endproperty
  a_tap_still: assert property (p_tap_still)
    else $error("tap moved without a tck edge");

endmodule : jcc_tap

/* verification/jcc_host.sv */
// host model driving the tap pins of the configuration block
`timescale 1ns/1ps
module jcc_host
#(
  parameter int unsigned IR_W = 10
)
(
  // clock
  input  wire logic clk,
  // tap pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // tck low two and high three core cycles, so every edge is seen
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk);
    #1;
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (2) @(posedge clk);
    #1;
    q = tdo;
    tck = 1'b1;
    repeat (2) @(posedge clk);
  endtask : step

  // data line not in use shows the inverse of its last value
  task automatic move(input logic m);
    logic q;
    step(m, ~tdi, q);
  endtask : move

  // opcode width is a parameter of both ends, shifted lsb first
  task automatic load_ir(input logic [IR_W-1:0] op);
    logic       q;
    logic [4:0] pre;
    pre = 5'b0_0110;
    for (int i = 0; i < 5; i++)
      move(pre[i]);
    for (int i = 0; i < IR_W; i++)
      step(i == IR_W - 1, op[i], q);
    move(1'b1);
    move(1'b0);
  endtask : load_ir

  // io reload flows are closed this way, except the one t_status ends by reset
  task automatic reset_tap;
    for (int i = 0; i < 5; i++)
      move(1'b1);
    move(1'b0);
  endtask : reset_tap

  // flash bytes travel over the tap, msb first as the flash expects
  task automatic shift_dr(input logic [7:0] d, output logic [7:0] q);
    move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 7; i >= 0; i--)
      step(i == 0, d[i], q[i]);
    move(1'b1);
    move(1'b0);
  endtask : shift_dr
endmodule : jcc_host

/* verification/jcc_top_tb.sv */
// self-checking bench for the jtag configuration control block
`timescale 1ns/1ps
module jcc_top_tb;
  import jcc_pkg::*;
  localparam int unsigned WAIT_CYC = 200;

  logic        core_clk, resetn, tck, tms, tdi, tdo, req_n, done, loaded, umode, asdo, stat_n;
  logic        sfc, sfc_q, active_serial_data_in, cs_n, oe, enter_um, recfg, io_rld, hiz, parked;
  logic [7:0]  rx, q;
  jcc_scheme_t scheme;
  int          num_errors = 0;
  int          check_count = 0;
  int          n_recfg = 0;
  int          n_io = 0;
  int          n_sclk = 0;

  jcc_top #(.PWRUP_WAIT(WAIT_CYC)) u_dut (
    .CORE_CLK(core_clk), .RESETN(resetn), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .SCHEME_SELECT_PINS(scheme), .CONFIG_REQUEST_PIN_N(req_n), .STATUS_LINE_N(stat_n),
    .CONFIG_DONE_LINE(done), .BRIDGE_LOADED(loaded), .USER_MODE_REACHED(umode),
    .SERIAL_FLASH_CLOCK(sfc), .ACTIVE_SERIAL_DATA_IN(active_serial_data_in), .FLASH_CHIP_SELECT_N(cs_n),
    .SERIAL_MEMORY_OE(oe), .ACTIVE_SERIAL_DATA_OUT(asdo), .ENTER_USER_MODE(enter_um),
    .RECONFIG_REQ(recfg), .IO_CHAIN_RELOAD(io_rld), .USER_IO_HIZ(hiz),
    .ACTIVE_CTRL_PARKED(parked)
  );

  jcc_host #(.IR_W(10)) u_host (.clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // pulse counters and a flash-side sampler on the rising serial clock
  always @(posedge core_clk)
  begin
    sfc_q <= sfc;
    if (recfg === 1'b1) n_recfg <= n_recfg + 1;
    if (io_rld === 1'b1) n_io <= n_io + 1;
    // the device reset that follows removes the loaded bridge
    if (recfg === 1'b1) loaded <= 1'b0;
    if (sfc === 1'b1 && sfc_q === 1'b0 && cs_n === 1'b0)
    begin
      if (n_sclk < 8) rx[7 - n_sclk] <= active_serial_data_in;
      n_sclk <= n_sclk + 1;
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic instr(input logic [9:0] op);
    u_host.load_ir(op);
    settle();
  endtask : instr

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic t_reset;
    chk("cs_n at reset", 8'h01, cs_n);
    chk("oe at reset", 8'h00, oe);
    chk("hiz at reset", 8'h00, hiz);
    chk("parked at reset", 8'h00, parked);
  endtask : t_reset

  task automatic t_powerup;
    int n0;
    req_n = 1'b0;
    repeat (50) @(posedge core_clk);
    #1;
    req_n = 1'b1;
    n0 = n_io;
    // early load lands inside the power-up window and must be ignored
    instr(OP_IO_LOAD_DEF);
    chk("io pulses early", 8'(n0), 8'(n_io));
    chk("hiz early", 8'h00, hiz);
    repeat (WAIT_CYC) @(posedge core_clk);
    instr(OP_IO_LOAD_DEF);
    chk("io pulses", 8'(n0 + 1), 8'(n_io));
    chk("hiz during io load", 8'h01, hiz);
    chk("no reconfig from io load", 8'h00, 8'(n_recfg));
    u_host.reset_tap();
    settle();
    chk("hiz after tap reset", 8'h00, hiz);
  endtask : t_powerup

  task automatic t_park;
    int r0;
    r0 = n_recfg;
    scheme = SCH_ACTIVE_SERIAL;
    instr(OP_PARK_DEF);
    chk("parked", 8'h01, parked);
    umode = 1'b1;
    settle();
    chk("unparked by user mode", 8'h00, parked);
    umode = 1'b0;
    instr(OP_PARK_DEF);
    u_host.reset_tap();
    settle();
    chk("serial unparked by tap reset", 8'h00, parked);
    scheme = SCH_ACTIVE_PARALLEL;
    instr(OP_PARK_DEF);
    u_host.reset_tap();
    settle();
    chk("parallel kept parked", 8'h01, parked);
    instr(OP_RESUME_DEF);
    chk("parked after resume", 8'h00, parked);
    chk("resume reconfig", 8'(r0 + 1), 8'(n_recfg));
    scheme = SCH_PASSIVE_SERIAL;
    instr(OP_PARK_DEF);
    chk("park passive", 8'h00, parked);
    instr(OP_RESUME_DEF);
    chk("resume passive", 8'(r0 + 2), 8'(n_recfg));
    repeat (WAIT_CYC) @(posedge core_clk);
  endtask : t_park

  // mid-run reset: the window restarts and ends early on the status rise
  task automatic t_status;
    int n0;
    n0 = n_io;
    instr(OP_IO_LOAD_DEF);
    chk("hiz before reset", 8'h01, hiz);
    resetn = 1'b0;
    stat_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk("hiz after reset", 8'h00, hiz);
    stat_n = 1'b1;
    instr(OP_IO_LOAD_DEF);
    chk("io after status rise", 8'(n0 + 2), 8'(n_io));
    u_host.reset_tap();
    settle();
    chk("hiz after status flow", 8'h00, hiz);
  endtask : t_status

  task automatic t_bridge;
    int r0;
    scheme = SCH_ACTIVE_SERIAL;
    done = 1'b0;
    loaded = 1'b1;
    settle();
    chk("user mode with done low", 8'h01, enter_um);
    chk("memory pins driven", 8'h01, oe);
    instr(OP_BRIDGE_DEF);
    r0 = n_recfg;
    n_sclk = 0;
    asdo = 1'b1;
    u_host.shift_dr(8'hA5, q);
    settle();
    chk("flash byte", 8'hA5, rx);
    chk("flash clocks", 8'h08, 8'(n_sclk));
    chk("flash data to tdo", 8'hFF, q);
    chk("cs_n after shift", 8'h01, cs_n);
    asdo = 1'b0;
    chk("no self reconfig", 8'(r0), 8'(n_recfg));
    instr(OP_RECONFIG_DEF);
    chk("reconfig pulse", 8'(r0 + 1), 8'(n_recfg));
    settle();
    chk("bridge removed", 8'h00, oe);
  endtask : t_bridge

  initial
  begin
    #(400_000);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    resetn = 1'b0;
    req_n = 1'b1;
    done = 1'b0;
    loaded = 1'b0;
    umode = 1'b0;
    asdo = 1'b0;
    stat_n = 1'b1;
    scheme = SCH_ACTIVE_SERIAL;
    repeat (3) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    t_reset();
    t_powerup();
    t_park();
    t_status();
    t_bridge();
    give_verdict();
  end
endmodule : jcc_top_tb
